//--- rtl/usf_ctrl.sv
// flow control, special detect, sleep and loopback control for a uart core
// assumes receiver hands one character per strobe; all other inputs are core-clock
// except the pins (rx, modem, autosleep) which pass a three-stage synchroniser
module usf_ctrl #(
  parameter int unsigned FIFO_DEPTH = 16,
  parameter longint unsigned IDLE_CYCLES = usf_pkg::IDLE_CYC,
  parameter int unsigned PUMP_CYCLES = usf_pkg::PUMP_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // configuration bits from the register file
  input wire logic [7:0] i_interrupt_enable_reg,
  input wire logic [7:0] i_enhanced_function_reg,
  input wire usf_pkg::usf_flow_t i_rx_flow_mode,
  input wire usf_pkg::usf_flow_t i_tx_flow_mode,
  input wire logic [1:0] i_line_control_reg,
  input wire logic [7:0] i_modem_control_reg,
  input wire logic [7:0] i_transmission_control_reg,
  input wire logic [15:0] i_divisor,
  input wire logic i_chars_we,
  input wire usf_pkg::usf_chars_t i_chars,
  input wire logic i_other_int_pending,
  input wire logic i_modem_status_read,
  // character path
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_char,
  output logic o_rx_fifo_valid,
  output logic [7:0] o_rx_fifo_data,
  input wire logic i_rx_fifo_ready,
  output logic o_rx_overrun,
  // transmitter hooks
  input wire logic i_tx_shift_out,
  input wire logic i_tx_busy,
  input wire logic i_tx_char_done,
  input wire logic i_tx_load,
  output logic o_tx_halt,
  output logic o_flow_send,
  output logic [7:0] o_flow_char,
  input wire logic i_flow_taken,
  // pins
  input wire logic i_rx_pin,
  input wire usf_pkg::usf_modem_t i_modem_pin,
  input wire logic i_charge_pump_autosleep_pin,
  input wire logic i_rts,
  input wire logic i_dtr,
  output logic o_tx_pin,
  output logic o_rts_pin,
  output logic o_dtr_pin,
  output logic o_rx_core,
  output usf_pkg::usf_modem_t o_modem_core,
  output logic o_hw_flow_on,
  // status
  output logic o_interrupt,
  output logic o_xoff_flag,
  output logic o_isr_bit4,
  output logic [3:0] o_modem_change,
  output logic o_core_sleep,
  output logic o_pump_off,
  output logic o_pump_ready,
  output logic o_full_sleep
);
  logic loop;
  logic [7:0] mask;
  usf_pkg::usf_chars_t chars;
  // flow characters clear on reset, writable afterwards
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      chars <= '{default: usf_pkg::CHR_RESET};
    end else if (i_chars_we) begin
      chars <= i_chars;
    end
  end
  assign loop = i_modem_control_reg[usf_pkg::MCR_LOOP_BIT];
  // word length mask 5..8 bits
  always_comb begin
    case (i_line_control_reg)
      2'b00: mask = 8'h1f;
      2'b01: mask = 8'h3f;
      2'b10: mask = 8'h7f;
      default: mask = 8'hff;
    endcase
  end
  // pin synchronisers: three stages, a change counts when stages 2 and 3 agree
  logic [2:0] rx_s;
  logic [2:0] acp_s;
  logic [2:0] mdm_s [4];
  logic rx_q;
  logic acp_q;
  logic [3:0] mdm_q;
  logic [3:0] mdm_raw;
  assign mdm_raw = i_modem_pin;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rx_s <= 3'b111;
      acp_s <= 3'b000;
      rx_q <= 1'b1;
      acp_q <= 1'b0;
    end else begin
      rx_s <= {rx_s[1:0], i_rx_pin};
      acp_s <= {acp_s[1:0], i_charge_pump_autosleep_pin};
      if (rx_s[1] == rx_s[2]) rx_q <= rx_s[2];
      if (acp_s[1] == acp_s[2]) acp_q <= acp_s[2];
    end
  end
  for (genvar g = 0; g < 4; g++) begin : g_mdm
    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        mdm_s[g] <= 3'b000;
        mdm_q[g] <= 1'b0;
      end else begin
        mdm_s[g] <= {mdm_s[g][1:0], mdm_raw[g]};
        if (mdm_s[g][1] == mdm_s[g][2]) mdm_q[g] <= mdm_s[g][2];
      end
    end
  end
  // loopback routing: modem inputs ignored, pins held
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rx_core <= 1'b1;
      o_modem_core <= '0;
      o_tx_pin <= 1'b1;
      o_rts_pin <= 1'b0;
      o_dtr_pin <= 1'b0;
      o_hw_flow_on <= 1'b0;
    end else begin
      o_rx_core <= loop ? i_tx_shift_out : rx_q;
      o_hw_flow_on <= !loop;
      if (!loop) begin
        o_tx_pin <= i_tx_shift_out;
        o_rts_pin <= i_rts;
        o_dtr_pin <= i_dtr;
        o_modem_core <= mdm_q;
      end
    end
  end
  // receive compare: pair tracking restarts on any other character
  logic [7:0] rc;
  logic on1;
  logic on2;
  logic off1;
  logic off2;
  logic pend_on;
  logic pend_off;
  logic hit_on;
  logic hit_off;
  logic special;
  logic rx_flow_on;
  assign rc = i_rx_char & mask;
  assign on1 = rc == (chars.xon1 & mask);
  assign on2 = rc == (chars.xon2 & mask);
  assign off1 = rc == (chars.xoff1 & mask);
  assign off2 = rc == (chars.second_stop_character & mask);
  assign rx_flow_on = i_rx_flow_mode != usf_pkg::USF_FLOW_OFF;
  always_comb begin
    hit_on = 1'b0;
    hit_off = 1'b0;
    case (i_rx_flow_mode)
      usf_pkg::USF_FLOW_ONE: begin
        hit_on = on1;
        hit_off = off1;
      end
      usf_pkg::USF_FLOW_TWO: begin
        hit_on = on2;
        hit_off = off2;
      end
      usf_pkg::USF_FLOW_PAIR: begin
        hit_on = pend_on && on2;
        hit_off = pend_off && off2;
      end
      default: begin
        hit_on = 1'b0;
        hit_off = 1'b0;
      end
    endcase
  end
  assign special = i_enhanced_function_reg[usf_pkg::EFR_SPECIAL_BIT] && off2 && !hit_off;
  // first-of-pair tracking; a first character is dropped from the fifo whether or not the pair completes
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pend_on <= 1'b0;
      pend_off <= 1'b0;
    end else if (i_rx_valid) begin
      pend_on <= (i_rx_flow_mode == usf_pkg::USF_FLOW_PAIR) && on1 && !hit_on;
      pend_off <= (i_rx_flow_mode == usf_pkg::USF_FLOW_PAIR) && off1 && !hit_off;
    end
  end
  // consumed flow characters never enter the fifo; a broken pair loses its first byte
  logic push;
  logic fifo_ready;
  logic [$clog2(FIFO_DEPTH):0] level;
  logic held;
  assign held = (i_rx_flow_mode == usf_pkg::USF_FLOW_PAIR) && (on1 || off1);
  assign push = i_rx_valid && !(rx_flow_on && (hit_on || hit_off || held));
  usf_fifo #(.WIDTH(usf_pkg::CHR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_valid(push),
    .i_data(i_rx_char),
    .o_ready(fifo_ready),
    .o_valid(o_rx_fifo_valid),
    .o_data(o_rx_fifo_data),
    .i_ready(i_rx_fifo_ready),
    .o_level(level)
  );
  // overrun when the fifo refuses a character
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) o_rx_overrun <= 1'b0;
    else o_rx_overrun <= push && !fifo_ready;
  end
  // suspend/resume and status flags; a set in the same cycle beats a clear
  logic suspend_req;
  logic int_pend;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      suspend_req <= 1'b0;
      o_xoff_flag <= 1'b0;
      o_isr_bit4 <= 1'b0;
    end else if (i_rx_valid) begin
      if (hit_off) suspend_req <= 1'b1;
      else if (hit_on && suspend_req) suspend_req <= 1'b0;
      if (hit_off && i_interrupt_enable_reg[usf_pkg::IER_XOFF_BIT]) begin
        o_xoff_flag <= 1'b1;
        o_isr_bit4 <= 1'b1;
      end else if (special) begin
        o_isr_bit4 <= 1'b1;
      end else if (hit_on && suspend_req) begin
        o_xoff_flag <= 1'b0;
        o_isr_bit4 <= 1'b0;
      end
    end
  end
  // halt lands only between characters, so a character in flight completes
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) o_tx_halt <= 1'b0;
    else if (!suspend_req) o_tx_halt <= 1'b0;
    else if (!i_tx_busy || i_tx_char_done) o_tx_halt <= 1'b1;
  end
  assign int_pend = o_xoff_flag || o_isr_bit4 || i_other_int_pending;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) o_interrupt <= 1'b0;
    else o_interrupt <= int_pend;
  end
  // threshold sender: one or two characters per event
  logic halted;
  logic [1:0] send_left;
  logic sending_off;
  logic [3:0] halt_lvl;
  logic [3:0] resume_lvl;
  logic tx_flow_on;
  assign halt_lvl = i_transmission_control_reg[3:0];
  assign resume_lvl = i_transmission_control_reg[7:4];
  assign tx_flow_on = i_tx_flow_mode != usf_pkg::USF_FLOW_OFF;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      halted <= 1'b0;
      send_left <= 2'd0;
      sending_off <= 1'b0;
    end else if (send_left != 2'd0) begin
      if (i_flow_taken) send_left <= send_left - 2'd1;
    end else if (tx_flow_on && !halted && level >= 5'(halt_lvl)) begin
      halted <= 1'b1;
      sending_off <= 1'b1;
      send_left <= (i_tx_flow_mode == usf_pkg::USF_FLOW_PAIR) ? 2'd2 : 2'd1;
    end else if (halted && level <= 5'(resume_lvl)) begin
      halted <= 1'b0;
      sending_off <= 1'b0;
      send_left <= (i_tx_flow_mode == usf_pkg::USF_FLOW_PAIR) ? 2'd2 : 2'd1;
    end
  end
  // pick the character to send; pair sends first then second
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_flow_send <= 1'b0;
      o_flow_char <= usf_pkg::CHR_RESET;
    end else begin
      o_flow_send <= (send_left != 2'd0) && !(i_flow_taken && send_left == 2'd1);
      if (send_left == 2'd2 || i_tx_flow_mode == usf_pkg::USF_FLOW_ONE) begin
        o_flow_char <= sending_off ? chars.xoff1 : chars.xon1;
      end else begin
        o_flow_char <= sending_off ? chars.second_stop_character : chars.xon2;
      end
    end
  end
  // modem change bits, cleared by a status read; set wins
  logic [3:0] mdm_prev;
  logic [3:0] mdm_chg;
  logic [3:0] mdm_rise;
  assign mdm_chg = loop ? 4'h0 : (mdm_q ^ mdm_prev);
  assign mdm_rise = loop ? 4'h0 : (mdm_q & ~mdm_prev);
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      mdm_prev <= 4'h0;
      o_modem_change <= 4'h0;
    end else begin
      mdm_prev <= mdm_q;
      o_modem_change <= (i_modem_status_read ? 4'h0 : o_modem_change) | mdm_chg;
    end
  end
  // core sleep: re-evaluated each cycle, so it stays armed while enabled
  logic rx_prev;
  logic rx_start;
  logic wake;
  logic may_sleep;
  assign rx_start = rx_prev && !rx_q;
  assign wake = rx_start || i_tx_load || (mdm_chg != 4'h0);
  assign may_sleep = !int_pend && (i_divisor != 16'h0000)
    && i_interrupt_enable_reg[usf_pkg::IER_SLEEP_BIT]
    && (o_modem_change == 4'h0) && rx_q && !i_tx_busy;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rx_prev <= 1'b1;
      o_core_sleep <= 1'b0;
    end else begin
      rx_prev <= rx_q;
      if (wake || !may_sleep) o_core_sleep <= 1'b0;
      else o_core_sleep <= 1'b1;
    end
  end
  // charge pump idle counter and wake delay
  localparam int unsigned IW = $clog2(IDLE_CYCLES + 1);
  localparam int unsigned PW = $clog2(PUMP_CYCLES + 1);
  logic [IW-1:0] idle_cnt;
  logic [PW-1:0] pump_cnt;
  logic pump_wake;
  assign pump_wake = rx_start || i_tx_load || (mdm_rise != 4'h0);
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      idle_cnt <= '0;
      o_pump_off <= 1'b0;
      o_full_sleep <= 1'b0;
    end else begin
      if (!acp_q || pump_wake || i_tx_busy || mdm_q != 4'h0) idle_cnt <= '0;
      else if (idle_cnt != IW'(IDLE_CYCLES)) idle_cnt <= idle_cnt + 1'b1;
      if (!acp_q || pump_wake) o_pump_off <= 1'b0;
      else if (o_core_sleep || idle_cnt == IW'(IDLE_CYCLES)) o_pump_off <= 1'b1;
      o_full_sleep <= acp_q && o_core_sleep && !wake;
    end
  end
  // pump ready out of reset; after a pump-off, ready again only after the restart delay
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pump_cnt <= '0;
      o_pump_ready <= 1'b1;
    end else if (o_pump_off) begin
      pump_cnt <= '0;
      o_pump_ready <= 1'b0;
    end else if (pump_cnt != PW'(PUMP_CYCLES)) begin
      pump_cnt <= pump_cnt + 1'b1;
    end else begin
      o_pump_ready <= 1'b1;
    end
  end
  // checks next to the logic
  sequence off_char_s;
    i_rx_valid && rx_flow_on && hit_off;
  endsequence
  xoff_suspend_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    off_char_s |=> suspend_req) else $error("stop match did not suspend");
  halt_wait_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(o_tx_halt) |-> !$past(i_tx_busy) || $past(i_tx_char_done))
    else $error("halt cut a character");
  xoff_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    off_char_s and i_interrupt_enable_reg[usf_pkg::IER_XOFF_BIT] |=> o_xoff_flag ##1 o_interrupt)
    else $error("stop flag or interrupt missing");
  consumed_chr_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    off_char_s |-> !push) else $error("flow char stored");
  loop_route_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    loop && $past(loop) |-> $stable(o_tx_pin) && o_rx_core == $past(i_tx_shift_out))
    else $error("loopback routing wrong");
  hwflow_loop_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    loop |=> !o_hw_flow_on) else $error("hw flow on in loopback");
  no_sleep_int_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    int_pend |=> !o_core_sleep) else $error("slept with interrupt");
  full_sleep_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_full_sleep |-> $past(acp_q) && $past(o_core_sleep))
    else $error("full sleep without cause");
endmodule

//--- rtl/usf_pkg.sv
// package for the uart flow control, sleep and loopback block
// assumes one 200 mhz core clock and a synchronous active-low reset
// Functional notes
// - with soft flow on, compare received characters against stop and resume values
// - on a stop match, transmitter halts after the current character completes
// - stop match with enable bit 5 set raises stop flag and interrupt
// - while suspended, a resume match restarts transmit and clears status bit 4
// - reset clears all four flow characters to zero; software may rewrite
// - double mode compares two consecutive characters against first and second values
// - characters consumed as flow matches never reach the receive fifo
// - receive fill reaching halt threshold low nibble sends stop character(s)
// - after halt, fill dropping to resume threshold sends resume character(s)
// - resume threshold is the upper nibble; software keeps halt above resume
// - special detect compares with second stop value, stores it, sets status bit 4
// - comparisons use only the configured word length of 5 to 8 bits
// - sleep needs no interrupt, nonzero divisor, enable, clear modem changes, idle rx
// - sleeping core wakes on rx start, transmit write, or modem input change
// - core resleeps once interrupts are clear and never sleeps while one pends
// - after modem wake, host reads modem status to clear change bits
// - automatic sleep stays armed until software clears the sleep enable
// - autosleep pin high: pump off after no tx, low modem, 30 s idle
// - pump wakes on rx start, tx load, or modem rising edge; about 45 us
// - full sleep when core asleep and pin high; leaves on pin low or wake
// - modem control bit 4 loops transmit shift output into receive input
// - in loopback tx, rts and dtr hold and modem inputs are ignored
// - hardware rts/cts flow control is off during loopback
package usf_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam longint unsigned IDLE_SEC = 30;
  localparam longint unsigned IDLE_CYC = IDLE_SEC * 64'(CLK_MHZ) * 64'd1000000;
  localparam int unsigned PUMP_US = 45;
  localparam int unsigned PUMP_CYC = PUMP_US * CLK_MHZ;
  localparam int unsigned IER_SLEEP_BIT = 4;
  localparam int unsigned IER_XOFF_BIT = 5;
  localparam int unsigned EFR_SPECIAL_BIT = 5;
  localparam int unsigned MCR_LOOP_BIT = 4;
  localparam int unsigned CHR_W = 8;
  localparam logic [7:0] CHR_RESET = 8'h00;
  // soft flow compare modes: off, single char 1, single char 2, double pair
  typedef enum logic [1:0] {
    USF_FLOW_OFF = 2'b00,
    USF_FLOW_ONE = 2'b01,
    USF_FLOW_TWO = 2'b10,
    USF_FLOW_PAIR = 2'b11
  } usf_flow_t;
  // characters programmed by software
  typedef struct packed {
    logic [7:0] xon1;
    logic [7:0] xon2;
    logic [7:0] xoff1;
    logic [7:0] second_stop_character;
  } usf_chars_t;
  // modem inputs, true level
  typedef struct packed {
    logic cts;
    logic dsr;
    logic cd;
    logic ri;
  } usf_modem_t;
endpackage

//--- rtl/usf_fifo.sv
// parameterised valid/ready fifo for received characters
// assumes both sides on the same clock; no read-during-full bypass
module usf_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready,
  output logic [$clog2(DEPTH):0] o_level
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_ready = count != (AW+1)'(DEPTH);
  assign o_level = count;
  assign next_rd_ptr = !pop ? rd_ptr : (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  // registered head; a push landing on the next head slot bypasses the array
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
    o_data <= (push && next_rd_ptr == wr_ptr) ? i_data : mem[next_rd_ptr];
  end
  // pointers wrap at depth so non-power-of-two depths work
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      o_valid <= next_count != '0;
    end
  end
endmodule

//--- dv/usf_far_end.sv
// far-end model: remote sender of received characters, taker of flow characters
// assumes the bench clock; drives on the falling edge; lag sets how slow it takes
module usf_far_end (
  input wire logic i_core_clk,
  input wire logic i_flow_send,
  input wire logic [7:0] i_flow_char,
  output logic o_rx_valid,
  output logic [7:0] o_rx_char,
  output logic o_flow_taken
);
  timeunit 1ns;
  timeprecision 100ps;
  int lag = 0;
  int waited = 0;
  logic [7:0] sent[$];

  // quiet line at time zero
  initial begin
    o_rx_valid = 1'b0;
    o_rx_char = 8'h00;
    o_flow_taken = 1'b0;
  end

  // characters go out back to back, one per cycle
  task automatic send(input logic [7:0] seq[$]);
    foreach (seq[i]) begin
      o_rx_valid = 1'b1;
      o_rx_char = seq[i];
      @(negedge i_core_clk);
    end
    o_rx_valid = 1'b0;
    o_rx_char = ~o_rx_char; // released: no stale character left showing
  endtask

  // take each flow character after lag cycles; skip the cycle after a take
  always @(negedge i_core_clk) begin
    o_flow_taken <= i_flow_send === 1'b1 && !o_flow_taken && waited >= lag;
    if (i_flow_send === 1'b1 && !o_flow_taken) begin
      if (waited < lag) begin
        waited <= waited + 1;
      end else begin
        sent.push_back(i_flow_char);
        waited <= 0;
      end
    end
  end
endmodule

//--- dv/uart_swflow_sleep_loopback_tb.sv
// self-checking bench for the flow control, sleep and loopback block
// assumes usf_pkg, usf_fifo, usf_ctrl and usf_far_end are compiled first
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
`define WAIT_UP(c, n) for (int k = 0; k < (n) && (c) !== 1'b1; k++) @(negedge i_core_clk);
module uart_swflow_sleep_loopback_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned IDLE = 100; // idle span cut from seconds to cycles
  localparam int unsigned PUMP = 10;
  logic i_core_clk = 1'b0;
  logic i_rst_n, i_chars_we, i_other_int_pending, i_modem_status_read, i_rx_fifo_ready;
  logic i_tx_shift_out, i_tx_busy, i_tx_char_done, i_tx_load, i_rx_pin;
  logic i_charge_pump_autosleep_pin, i_rts, i_dtr, i_rx_valid, i_flow_taken;
  logic [7:0] i_interrupt_enable_reg, i_enhanced_function_reg, i_modem_control_reg;
  logic [7:0] i_transmission_control_reg, i_rx_char, o_rx_fifo_data, o_flow_char;
  logic [1:0] i_line_control_reg;
  logic [15:0] i_divisor;
  usf_pkg::usf_flow_t i_rx_flow_mode, i_tx_flow_mode;
  usf_pkg::usf_chars_t i_chars;
  usf_pkg::usf_modem_t i_modem_pin, o_modem_core;
  logic o_rx_fifo_valid, o_rx_overrun, o_tx_halt, o_flow_send, o_tx_pin, o_rts_pin;
  logic o_dtr_pin, o_rx_core, o_hw_flow_on, o_interrupt, o_xoff_flag, o_isr_bit4;
  logic o_core_sleep, o_pump_off, o_pump_ready, o_full_sleep;
  logic [3:0] o_modem_change;
  int fail_count = 0;
  int samples_checked = 0;
  int overruns = 0;

  usf_ctrl #(.FIFO_DEPTH(16), .IDLE_CYCLES(IDLE), .PUMP_CYCLES(PUMP)) uut (
    .i_core_clk, .i_rst_n, .i_interrupt_enable_reg, .i_enhanced_function_reg,
    .i_rx_flow_mode, .i_tx_flow_mode, .i_line_control_reg, .i_modem_control_reg,
    .i_transmission_control_reg, .i_divisor, .i_chars_we, .i_chars, .i_other_int_pending,
    .i_modem_status_read, .i_rx_valid, .i_rx_char, .o_rx_fifo_valid, .o_rx_fifo_data,
    .i_rx_fifo_ready, .o_rx_overrun, .i_tx_shift_out, .i_tx_busy, .i_tx_char_done,
    .i_tx_load, .o_tx_halt, .o_flow_send, .o_flow_char, .i_flow_taken, .i_rx_pin,
    .i_modem_pin, .i_charge_pump_autosleep_pin, .i_rts, .i_dtr, .o_tx_pin, .o_rts_pin,
    .o_dtr_pin, .o_rx_core, .o_modem_core, .o_hw_flow_on, .o_interrupt, .o_xoff_flag,
    .o_isr_bit4, .o_modem_change, .o_core_sleep, .o_pump_off, .o_pump_ready, .o_full_sleep);
  usf_far_end far (.i_core_clk, .i_flow_send(o_flow_send), .i_flow_char(o_flow_char),
    .o_rx_valid(i_rx_valid), .o_rx_char(i_rx_char), .o_flow_taken(i_flow_taken));

  always #2.5 i_core_clk = ~i_core_clk;
  // overrun is a one-cycle pulse, so count it rather than poll it
  always @(posedge i_core_clk) if (o_rx_overrun === 1'b1) overruns++;

  task automatic tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  // every input back to a quiet value, then six cycles of reset
  task automatic do_reset();
    i_rst_n = 1'b0;
    i_interrupt_enable_reg = 8'h00;
    i_enhanced_function_reg = 8'h00;
    i_rx_flow_mode = usf_pkg::USF_FLOW_OFF;
    i_tx_flow_mode = usf_pkg::USF_FLOW_OFF;
    i_line_control_reg = 2'b11;
    i_modem_control_reg = 8'h00;
    i_transmission_control_reg = 8'h00;
    i_divisor = 16'h0000;
    i_chars_we = 1'b0;
    i_chars = 32'h0000_0000;
    i_other_int_pending = 1'b0;
    i_modem_status_read = 1'b0;
    i_rx_fifo_ready = 1'b0;
    i_tx_shift_out = 1'b1;
    i_tx_busy = 1'b0;
    i_tx_char_done = 1'b0;
    i_tx_load = 1'b0;
    i_rx_pin = 1'b1;
    i_modem_pin = 4'h0;
    i_charge_pump_autosleep_pin = 1'b0;
    i_rts = 1'b0;
    i_dtr = 1'b0;
    tick(6);
    i_rst_n = 1'b1;
    tick(5); // pin synchronisers settle
  endtask

  task automatic load_chars(input logic [31:0] c);
    i_chars = c;
    i_chars_we = 1'b1;
    tick(1);
    i_chars_we = 1'b0;
  endtask

  // cleared characters make 0x00 a stop; a rewrite then makes it a resume
  task automatic t_reset();
    do_reset();
    `CHK(o_tx_pin, 1'b1)
    `CHK(o_pump_ready, 1'b1)
    i_rx_flow_mode = usf_pkg::USF_FLOW_ONE;
    i_interrupt_enable_reg = 8'h20;
    far.send('{8'h00});
    tick(3);
    `CHK(o_xoff_flag, 1'b1)
    `CHK(o_rx_fifo_valid, 1'b0)
    load_chars(32'h0000_1300);
    far.send('{8'h00});
    tick(3);
    `CHK(o_xoff_flag, 1'b0)
    $display("t_reset done");
  endtask

  // single stop/resume with a 5-bit word and a busy transmitter
  task automatic t_single();
    do_reset();
    load_chars(32'h1100_1300);
    i_line_control_reg = 2'b00;
    i_rx_flow_mode = usf_pkg::USF_FLOW_ONE;
    i_interrupt_enable_reg = 8'h20;
    i_tx_busy = 1'b1;
    far.send('{8'hF3});
    tick(3);
    `CHK(o_xoff_flag, 1'b1)
    `CHK(o_isr_bit4, 1'b1)
    `CHK(o_interrupt, 1'b1)
    `CHK(o_tx_halt, 1'b0)
    `CHK(o_rx_fifo_valid, 1'b0)
    i_tx_busy = 1'b0;
    i_tx_char_done = 1'b1;
    tick(1);
    i_tx_char_done = 1'b0;
    tick(2);
    `CHK(o_tx_halt, 1'b1)
    far.send('{8'h41});
    tick(2);
    `CHK(o_rx_fifo_valid, 1'b1)
    far.send('{8'h31});
    tick(3);
    `CHK(o_xoff_flag, 1'b0)
    `CHK(o_isr_bit4, 1'b0)
    `CHK(o_tx_halt, 1'b0)
    $display("t_single done");
  endtask

  // pair broken by another character, then a clean pair each way
  task automatic t_pair();
    do_reset();
    load_chars(32'h1112_1314);
    i_rx_flow_mode = usf_pkg::USF_FLOW_PAIR;
    i_interrupt_enable_reg = 8'h20;
    far.send('{8'h13, 8'h41, 8'h14});
    tick(3);
    `CHK(o_xoff_flag, 1'b0)
    far.send('{8'h13, 8'h14});
    tick(3);
    `CHK(o_xoff_flag, 1'b1)
    far.send('{8'h11, 8'h12});
    tick(3);
    `CHK(o_xoff_flag, 1'b0)
    i_rx_flow_mode = usf_pkg::USF_FLOW_TWO;
    far.send('{8'h14});
    tick(3);
    `CHK(o_xoff_flag, 1'b1)
    $display("t_pair done");
  endtask

  task automatic t_special();
    do_reset();
    load_chars(32'h0000_0055);
    i_enhanced_function_reg = 8'h20;
    i_interrupt_enable_reg = 8'h20;
    far.send('{8'h55});
    tick(3);
    `CHK(o_isr_bit4, 1'b1)
    `CHK(o_rx_fifo_valid, 1'b1)
    `CHK(o_rx_fifo_data, 8'h55)
    $display("t_special done");
  endtask

  // fill past full with a slow far end, then drain through resume level
  task automatic t_thresh();
    logic [7:0] q[$];
    do_reset();
    load_chars(32'h1112_1314);
    i_transmission_control_reg = 8'h24;
    i_tx_flow_mode = usf_pkg::USF_FLOW_ONE;
    far.lag = 3;
    overruns = 0;
    for (int i = 0; i < 17; i++) q.push_back(8'h20 + 8'(i));
    far.send(q);
    tick(4);
    `CHK(overruns, 1)
    `WAIT_UP(far.sent.size() == 1, 20)
    `CHK(far.sent[0], 8'h13)
    i_rx_fifo_ready = 1'b1;
    for (int i = 0; i < 16; i++) begin
      `CHK(o_rx_fifo_valid, 1'b1)
      `CHK(o_rx_fifo_data, 8'h20 + 8'(i))
      tick(1);
    end
    i_rx_fifo_ready = 1'b0;
    `CHK(o_rx_fifo_valid, 1'b0)
    tick(10);
    `CHK(far.sent.size(), 2)
    `CHK(far.sent[1], 8'h11)
    $display("t_thresh done");
  endtask

  task automatic t_sleep();
    do_reset();
    i_interrupt_enable_reg = 8'h10;
    tick(10);
    `CHK(o_core_sleep, 1'b0)
    i_divisor = 16'h0001;
    `WAIT_UP(o_core_sleep, 20)
    `CHK(o_core_sleep, 1'b1)
    i_charge_pump_autosleep_pin = 1'b1;
    tick(8);
    `CHK(o_full_sleep, 1'b1)
    i_charge_pump_autosleep_pin = 1'b0;
    tick(8);
    `CHK(o_full_sleep, 1'b0)
    i_other_int_pending = 1'b1;
    tick(3);
    `CHK(o_core_sleep, 1'b0)
    i_other_int_pending = 1'b0;
    `WAIT_UP(o_core_sleep, 20)
    i_modem_pin.cts = 1'b1;
    tick(8);
    `CHK(o_core_sleep, 1'b0)
    `CHK(|o_modem_change, 1'b1)
    tick(10);
    `CHK(o_core_sleep, 1'b0)
    i_modem_status_read = 1'b1;
    tick(1);
    i_modem_status_read = 1'b0;
    `WAIT_UP(o_core_sleep, 20)
    `CHK(o_core_sleep, 1'b1)
    i_tx_load = 1'b1;
    i_tx_busy = 1'b1;
    tick(1);
    i_tx_load = 1'b0;
    tick(4);
    `CHK(o_core_sleep, 1'b0)
    i_tx_busy = 1'b0;
    `WAIT_UP(o_core_sleep, 20)
    `CHK(o_core_sleep, 1'b1)
    i_rx_pin = 1'b0;
    tick(8);
    `CHK(o_core_sleep, 1'b0)
    i_rx_pin = 1'b1;
    i_interrupt_enable_reg = 8'h00;
    tick(20);
    `CHK(o_core_sleep, 1'b0)
    $display("t_sleep done");
  endtask

  task automatic t_pump();
    do_reset();
    i_charge_pump_autosleep_pin = 1'b1;
    `WAIT_UP(o_pump_off, IDLE + 20)
    `CHK(o_pump_off, 1'b1)
    i_modem_pin.dsr = 1'b1;
    tick(8);
    `CHK(o_pump_off, 1'b0)
    `WAIT_UP(o_pump_ready, PUMP + 10)
    `CHK(o_pump_ready, 1'b1)
    $display("t_pump done");
  endtask

  // loopback: pins hold, modem inputs ignored, hardware flow off
  task automatic t_loop();
    do_reset();
    i_modem_control_reg = 8'h10;
    tick(3);
    i_tx_shift_out = 1'b0;
    i_rts = 1'b1;
    i_dtr = 1'b1;
    i_modem_pin = 4'hF;
    tick(8);
    `CHK(o_rx_core, 1'b0)
    `CHK(o_tx_pin, 1'b1)
    `CHK(o_rts_pin, 1'b0)
    `CHK(o_dtr_pin, 1'b0)
    `CHK(o_modem_core, 4'h0)
    `CHK(o_hw_flow_on, 1'b0)
    $display("t_loop done");
  endtask

  task automatic close_out();
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // whole run is a few hundred cycles; cut off well beyond that
  initial begin
    #100000;
    fail_count++;
    close_out();
  end

  initial begin
    do_reset();
    t_reset();
    t_single();
    t_pair();
    t_special();
    t_thresh();
    t_sleep();
    t_pump();
    t_loop();
    close_out();
  end
endmodule
